// ==== hdl/ikw_pkg.sv ====
`default_nettype none
package ikw_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // register byte offsets
  localparam logic [7:0] OFS_KEY      = 8'h00;
  localparam logic [7:0] OFS_PRESCALE = 8'h04;
  localparam logic [7:0] OFS_RELOAD   = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0C;

  // key command values
  localparam int          KEY_W       = 16;
  localparam logic [15:0] KEY_START   = 16'hCCCC;
  localparam logic [15:0] KEY_REFRESH = 16'hAAAA;
  localparam logic [15:0] KEY_UNLOCK  = 16'h5555;

  // counter and field widths, reset values
  localparam int          CNT_W        = 12;
  localparam int          PRE_W        = 3;
  localparam int          DIVCNT_W     = 8;
  localparam logic [11:0] CNT_INIT     = 12'hFFF;
  localparam logic [11:0] CNT_ZERO     = 12'h000;
  localparam logic [2:0]  PRESCALE_RST = 3'h0;
  localparam logic [11:0] RELOAD_RST   = 12'hFFF;

  // prescale divider: codes up to PRE_CODE_LAST give 4 << code, above that 256
  localparam logic [2:0] PRE_CODE_LAST = 3'h5;
  localparam logic [8:0] DIV_BASE      = 9'h004;
  localparam logic [8:0] DIV_ONE       = 9'h001;
  localparam logic [7:0] DIV_MAX_MASK  = 8'hFF;

  // status bit positions
  localparam int STS_PRESCALE_BIT = 0;
  localparam int STS_RELOAD_BIT   = 1;

  // commands carried into the counter side
  localparam int CMD_W           = 2;
  localparam int CMD_START_BIT   = 0;
  localparam int CMD_REFRESH_BIT = 1;

  // lane groups
  localparam logic [3:0] STRB_LO  = 4'h1;
  localparam logic [3:0] STRB_LO2 = 4'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {WS_COLLECT = 1'b0, WS_RESP = 1'b1} ikw_wr_state_t;
  typedef enum logic {RS_IDLE = 1'b0, RS_DATA = 1'b1} ikw_rd_state_t;
  typedef enum logic [1:0] {
    CS_IDLE  = 2'b00,
    CS_RUN   = 2'b01,
    CS_FIRED = 2'b10
  } ikw_cnt_state_t;
endpackage
`default_nettype wire

// ==== hdl/ikw_xfer_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface ikw_xfer_if #(parameter int W = 1);
  logic         launch;
  logic [W-1:0] launch_data;
  logic         busy;
  logic         land;
  logic [W-1:0] land_data;

  modport user (output launch, output launch_data, input busy, input land, input land_data);
  modport fab  (input launch, input launch_data, output busy, output land, output land_data);
endinterface
`default_nettype wire

// ==== hdl/ikw_xfer.sv ====
`timescale 1ns/100ps
`default_nettype none
module ikw_xfer #(
  parameter int           W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic osc_tick,
  ikw_xfer_if.fab   xf
);
  import ikw_pkg::*;

  logic         req;
  logic         req_s1;
  logic         req_s2;
  logic         seen;
  logic         ack_s1;
  logic         ack_s2;
  logic [W-1:0] hold;

  // busy spans the whole round trip, request out and acknowledge back
  assign xf.busy = req ^ ack_s2;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req  <= 1'b0;
      hold <= '0;
    end else if (xf.launch && !xf.busy) begin
      req  <= ~req;
      hold <= xf.launch_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
    end else begin
      req_s1 <= req;
      req_s2 <= req_s1;
    end
  end

  // far side only moves on oscillator ticks; no stop input can abort it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen         <= 1'b0;
      xf.land      <= 1'b0;
      xf.land_data <= RESET_VAL;
    end else begin
      xf.land <= 1'b0;
      if (osc_tick && (req_s2 != seen)) begin
        seen         <= req_s2;
        xf.land      <= 1'b1;
        xf.land_data <= hold;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= seen;
      ack_s2 <= ack_s1;
    end
  end
endmodule // ikw_xfer
`default_nettype wire

// ==== hdl/ikw_top.sv ====
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module ikw_top (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [ikw_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [ikw_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [ikw_pkg::STRB_W-1:0]  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [ikw_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [ikw_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        osc_tick,
  input  wire logic                        software_start_option,
  input  wire logic                        watchdog_reset_allow,
  input  wire logic                        debug_halt,
  input  wire logic                        debug_freeze_select,
  output logic                             watchdog_reset_out,
  output logic                             watchdog_wakeup
);
  import ikw_pkg::*;

  ikw_wr_state_t        wr_state;
  ikw_rd_state_t        rd_state;
  ikw_cnt_state_t       cnt_state;
  logic                 aw_held;
  logic [ADDR_W-1:0]    aw_addr;
  logic                 w_held;
  logic [DATA_W-1:0]    w_data;
  logic [STRB_W-1:0]    w_strb;
  logic                 do_write;
  logic                 addr_mapped_wr;
  logic                 key_write;
  logic [KEY_W-1:0]     key_value_field;
  logic                 unlocked;
  logic                 wr_prescale;
  logic                 wr_reload;
  logic [CMD_W-1:0]     cmd_pend;
  logic [CMD_W-1:0]     cmd_new;
  logic                 cmd_launch;
  logic                 hw_mode;
  logic                 strap_done;
  logic [CNT_W-1:0]     count;
  logic                 reloaded;
  logic [DIVCNT_W-1:0]  div_cnt;
  logic [DIVCNT_W-1:0]  div_mask;
  logic                 freeze;
  logic                 tick_en;
  logic                 dec;
  logic                 at_zero;
  logic                 start_land;
  logic                 refresh_land;
  logic [DATA_W-1:0]    next_rdata;
  logic [1:0]           next_rresp;

  ikw_xfer_if #(.W(PRE_W)) pre_if ();
  ikw_xfer_if #(.W(CNT_W)) rld_if ();
  ikw_xfer_if #(.W(CMD_W)) cmd_if ();

  ikw_xfer #(.W(PRE_W), .RESET_VAL(PRESCALE_RST)) u_pre_xfer (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .osc_tick (osc_tick),
    .xf       (pre_if.fab)
  );

  ikw_xfer #(.W(CNT_W), .RESET_VAL(RELOAD_RST)) u_rld_xfer (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .osc_tick (osc_tick),
    .xf       (rld_if.fab)
  );

  ikw_xfer #(.W(CMD_W), .RESET_VAL({CMD_W{1'b0}})) u_cmd_xfer (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .osc_tick (osc_tick),
    .xf       (cmd_if.fab)
  );

  // ---------------- write channel ----------------
  assign s_axi_awready = !aw_held && (wr_state == WS_COLLECT);
  assign s_axi_wready  = !w_held && (wr_state == WS_COLLECT);
  assign s_axi_bvalid  = (wr_state == WS_RESP);
  assign do_write      = (wr_state == WS_COLLECT) && aw_held && w_held;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_held <= 1'b0;
    end
  end

  assign addr_mapped_wr = (aw_addr == OFS_KEY) || (aw_addr == OFS_PRESCALE) ||
                          (aw_addr == OFS_RELOAD) || (aw_addr == OFS_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state    <= WS_COLLECT;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      case (wr_state)
        WS_COLLECT: begin
          if (do_write) begin
            wr_state    <= WS_RESP;
            s_axi_bresp <= addr_mapped_wr ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WS_RESP: begin
          if (s_axi_bready) begin
            wr_state <= WS_COLLECT;
          end
        end
        default: wr_state <= WS_COLLECT;
      endcase
    end
  end

  // ---------------- key register and protection ----------------
  assign key_write = do_write && (aw_addr == OFS_KEY) && ((w_strb & STRB_LO2) == STRB_LO2);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_value_field <= '0;
      unlocked        <= 1'b0;
    end else if (key_write) begin
      key_value_field <= w_data[KEY_W-1:0];
      // any key but unlock, refresh included, closes the gate again
      unlocked        <= (w_data[KEY_W-1:0] == KEY_UNLOCK);
    end
  end

  assign wr_prescale = do_write && (aw_addr == OFS_PRESCALE) && unlocked &&
                       !pre_if.busy && ((w_strb & STRB_LO) == STRB_LO);
  assign wr_reload   = do_write && (aw_addr == OFS_RELOAD) && unlocked &&
                       !rld_if.busy && ((w_strb & STRB_LO2) == STRB_LO2);

  assign pre_if.launch      = wr_prescale;
  assign pre_if.launch_data = w_data[PRE_W-1:0];
  assign rld_if.launch      = wr_reload;
  assign rld_if.launch_data = w_data[CNT_W-1:0];

  // key commands queue here while an earlier command is still crossing
  always_comb begin
    cmd_new = '0;
    if (key_write && (w_data[KEY_W-1:0] == KEY_START) && !hw_mode) begin
      cmd_new[CMD_START_BIT] = 1'b1;
    end
    if (key_write && (w_data[KEY_W-1:0] == KEY_REFRESH)) begin
      cmd_new[CMD_REFRESH_BIT] = 1'b1;
    end
  end

  assign cmd_launch         = (|cmd_pend) && !cmd_if.busy;
  assign cmd_if.launch      = cmd_launch;
  assign cmd_if.launch_data = cmd_pend;

  // a key arriving in the launch cycle survives: set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_pend <= '0;
    end else begin
      cmd_pend <= (cmd_pend & ~{CMD_W{cmd_launch}}) | cmd_new;
    end
  end

  // ---------------- start option strap ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_done <= 1'b0;
      hw_mode    <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      hw_mode    <= !software_start_option;
    end
  end

  // ---------------- counter side ----------------
  assign start_land   = cmd_if.land && cmd_if.land_data[CMD_START_BIT];
  assign refresh_land = cmd_if.land && cmd_if.land_data[CMD_REFRESH_BIT];

  // stop mode has no gate here: the oscillator paces the count, and only debug freeze halts it
  assign freeze  = debug_halt && debug_freeze_select;
  assign tick_en = osc_tick && !freeze && (cnt_state == CS_RUN);

  always_comb begin
    if (pre_if.land_data > PRE_CODE_LAST) begin
      div_mask = DIV_MAX_MASK;
    end else begin
      div_mask = DIVCNT_W'((DIV_BASE << pre_if.land_data) - DIV_ONE);
    end
  end

  assign dec     = tick_en && (div_cnt >= div_mask);
  assign at_zero = (count == CNT_ZERO);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= '0;
    end else if (refresh_land || start_land || dec) begin
      div_cnt <= '0;
    end else if (tick_en) begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_state <= CS_IDLE;
      count     <= CNT_INIT;
      reloaded  <= 1'b0;
    end else begin
      case (cnt_state)
        CS_IDLE: begin
          if (start_land || hw_mode) begin
            cnt_state <= CS_RUN;
            count     <= CNT_INIT;
            reloaded  <= 1'b0;
          end
          // a refresh landing together with start must not be lost
          if (refresh_land) begin
            count    <= rld_if.land_data;
            reloaded <= 1'b1;
          end
        end
        CS_RUN: begin
          if (refresh_land) begin
            count    <= rld_if.land_data;
            reloaded <= 1'b1;
          end else if (at_zero && watchdog_reset_allow) begin
            cnt_state <= CS_FIRED;
          end else if (dec) begin
            if (at_zero) begin
              // no reset allowed: roll into the next round
              count <= reloaded ? rld_if.land_data : CNT_INIT;
            end else begin
              count <= count - 1'b1;
            end
          end
        end
        CS_FIRED: begin
          // held until the system reset pulls aresetn
          cnt_state <= CS_FIRED;
        end
        default: cnt_state <= CS_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_reset_out <= 1'b0;
      watchdog_wakeup    <= 1'b0;
    end else begin
      watchdog_reset_out <= (cnt_state == CS_FIRED) ||
                            ((cnt_state == CS_RUN) && at_zero && !refresh_land &&
                             watchdog_reset_allow);
      watchdog_wakeup    <= (cnt_state == CS_RUN) && at_zero && !refresh_land &&
                            watchdog_reset_allow;
    end
  end

  // ---------------- read channel ----------------
  assign s_axi_arready = (rd_state == RS_IDLE);
  assign s_axi_rvalid  = (rd_state == RS_DATA);

  // fields read back from the counter side, stale while busy
  always_comb begin
    next_rdata = '0;
    next_rresp = RESP_OKAY;
    case (s_axi_araddr)
      OFS_KEY:      next_rdata = '0;
      OFS_PRESCALE: next_rdata[PRE_W-1:0] = pre_if.land_data;
      OFS_RELOAD:   next_rdata[CNT_W-1:0] = rld_if.land_data;
      OFS_STATUS: begin
        next_rdata[STS_PRESCALE_BIT] = pre_if.busy;
        next_rdata[STS_RELOAD_BIT]   = rld_if.busy;
      end
      default:      next_rresp = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state    <= RS_IDLE;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      case (rd_state)
        RS_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state    <= RS_DATA;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
          end
        end
        RS_DATA: begin
          if (s_axi_rready) begin
            rd_state <= RS_IDLE;
          end
        end
        default: rd_state <= RS_IDLE;
      endcase
    end
  end
endmodule // ikw_top
`default_nettype wire

// ==== dv/ikw_top_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module ikw_top_properties (
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [ikw_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  input wire logic                       watchdog_reset_allow,
  input wire logic                       debug_halt,
  input wire logic                       debug_freeze_select,
  input wire logic                       watchdog_reset_out,
  input wire logic                       watchdog_wakeup
);
  import ikw_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##[1:2] s_axi_bvalid) else $error("write response missing");
  wr_block_a: assert property ((s_axi_awvalid && s_axi_awready |=> !s_axi_awready) and
    (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)) else $error("write taken twice");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rst_sticky_a:
    assert property (watchdog_reset_out |=> watchdog_reset_out) else $error("reset released");
  allow_gate_a:
    assert property ($rose(watchdog_reset_out) |-> $past(watchdog_reset_allow))
    else $error("reset raised while not allowed");
  wake_pulse_a:
    assert property ($rose(watchdog_reset_out) |-> watchdog_wakeup ##1 !watchdog_wakeup)
    else $error("wake-up pulse wrong");
  wake_cause_a:
    assert property (watchdog_wakeup |-> $rose(watchdog_reset_out)) else $error("stray wake-up");
  freeze_hold_a:
    assert property ((debug_halt && debug_freeze_select)[*4] |-> !$rose(watchdog_reset_out))
    else $error("timeout while frozen");
  cover property ($rose(watchdog_reset_out));
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ((debug_halt && debug_freeze_select)[*4]);
endmodule // ikw_top_properties
bind ikw_top ikw_top_properties u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .watchdog_reset_allow,
  .debug_halt, .debug_freeze_select, .watchdog_reset_out, .watchdog_wakeup);
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ikw_pkg::*;
  logic              aclk = 1'b0, aresetn = 1'b0, osc_tick = 1'b0, tick_en = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, rdv;
  logic [STRB_W-1:0] s_axi_wstrb = 4'hF;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rrs;
  logic              software_start_option = 1'b1, watchdog_reset_allow = 1'b1;
  logic              debug_halt = 1'b0, debug_freeze_select = 1'b0;
  logic              watchdog_reset_out, watchdog_wakeup;
  logic [15:0]       rnd = 16'hD994;
  int                bad_count = 0, cmp_count = 0, m_pre, m_rld, rl;
  bit                m_lock, m_bp, m_br;

  ikw_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .osc_tick, .software_start_option, .watchdog_reset_allow, .debug_halt,
    .debug_freeze_select, .watchdog_reset_out, .watchdog_wakeup);

  always #4 aclk = ~aclk;
  // one oscillator tick every second clock keeps timeouts short
  always @(posedge aclk) osc_tick <= tick_en & ~osc_tick;

  task automatic summarize();
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_up(input bit hit);
    if (hit) begin
      bad_count++;
      $display("Error at %0t: wait timeout", $time);
      summarize();
    end
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic [31:0] exp_resp(input logic [7:0] a);
    return (a > OFS_STATUS || a[1:0] != 2'h0) ? 32'(RESP_SLVERR) : 32'(RESP_OKAY);
  endfunction

  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      OFS_PRESCALE: return 32'(m_pre);
      OFS_RELOAD:   return 32'(m_rld);
      OFS_STATUS:   return {30'h0, m_br, m_bp};
      default:      return 32'h0;
    endcase
  endfunction

  function automatic int tper(input int code, input int r);
    return r * 2 * (code > 5 ? 256 : 4 << code);
  endfunction

  task automatic apply_rst();
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    m_pre = 0;
    m_rld = 'hFFF;
    m_lock = 1;
    m_bp = 0;
    m_br = 0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    give_up(n >= 50);
    chk(32'(s_axi_bresp), exp_resp(a));
    if (a == OFS_KEY)
      m_lock = d[15:0] != KEY_UNLOCK;
    else if (a == OFS_PRESCALE && !m_lock && !m_bp) begin
      m_pre = d[2:0];
      m_bp = 1;
    end
    else if (a == OFS_RELOAD && !m_lock && !m_br) begin
      m_rld = d[11:0];
      m_br = 1;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    give_up(n >= 50);
    rdv = s_axi_rdata;
    rrs = s_axi_rresp;
  endtask

  task automatic rdc(input logic [7:0] a);
    rd(a);
    chk(rdv, exp_rd(a));
    chk(32'(rrs), exp_resp(a));
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      rd(OFS_STATUS);
      n++;
    end while (rdv[1:0] !== 2'b00 && n < 100);
    chk(32'(rdv[1:0]), 0);
    give_up(rdv[1:0] !== 2'b00);
    m_bp = 0;
    m_br = 0;
  endtask

  // wide windows: divider phase and crossing delay are not pinned down
  task automatic wait_rst(input int lo, input int hi);
    int n;
    n = 0;
    while (watchdog_reset_out !== 1'b1 && n <= hi) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 1);
    give_up(n > hi);
  endtask

  task automatic prime(input int code, input int r);
    wr(OFS_KEY, {16'h0, KEY_UNLOCK});
    wr(OFS_PRESCALE, 32'(code));
    wr(OFS_RELOAD, 32'(r));
    wait_idle();
    rdc(OFS_PRESCALE);
    rdc(OFS_RELOAD);
    wr(OFS_KEY, {16'h0, KEY_START});
    wr(OFS_KEY, {16'h0, KEY_REFRESH});
  endtask

  initial begin
    apply_rst();
    for (int a = 0; a <= 16; a += 4) rdc(8'(a));
    wr(8'h10, 32'h1);
    wr(OFS_PRESCALE, 32'h5);
    rdc(OFS_PRESCALE);
    rnd = lfsr(rnd);
    wr(OFS_KEY, {16'h0, KEY_UNLOCK});
    wr(OFS_KEY, {20'h1, rnd[11:0]});
    wr(OFS_PRESCALE, 32'h5);
    rdc(OFS_PRESCALE);
    wr(OFS_KEY, {16'h0, KEY_UNLOCK});
    wr(OFS_KEY, {16'h0, KEY_REFRESH});
    wr(OFS_RELOAD, 32'h7);
    rdc(OFS_RELOAD);
    apply_rst();
    // oscillator stalled so the busy flags cannot clear yet
    tick_en <= 1'b0;
    wr(OFS_KEY, {16'h0, KEY_UNLOCK});
    wr(OFS_PRESCALE, 32'h3);
    rdc(OFS_STATUS);
    wr(OFS_PRESCALE, 32'h6);
    wr(OFS_RELOAD, {20'h0, rnd[11:0]});
    rdc(OFS_STATUS);
    tick_en <= 1'b1;
    wait_idle();
    rdc(OFS_PRESCALE);
    rdc(OFS_RELOAD);
    for (int c = 0; c < 8; c++) begin
      apply_rst();
      debug_halt <= c[0];
      rnd = lfsr(rnd);
      rl = 2 + int'(rnd[2:0]);
      prime(c, rl);
      wait_rst(tper(c, rl - 1), tper(c, rl + 1) + 40);
    end
    apply_rst();
    debug_halt <= 1'b0;
    watchdog_reset_allow <= 1'b0;
    prime(0, 40);
    repeat (480) @(posedge aclk);
    chk(32'(watchdog_reset_out), 0);
    watchdog_reset_allow <= 1'b1;
    wait_rst(100, 250);
    apply_rst();
    prime(0, 40);
    repeat (100) @(posedge aclk);
    debug_halt <= 1'b1;
    debug_freeze_select <= 1'b1;
    repeat (400) @(posedge aclk);
    chk(32'(watchdog_reset_out), 0);
    debug_halt <= 1'b0;
    wait_rst(190, 280);
    debug_freeze_select <= 1'b0;
    apply_rst();
    prime(0, 40);
    // each refresh lands well inside the 320-cycle round
    for (int k = 0; k < 3; k++) begin
      repeat (200) @(posedge aclk);
      wr(OFS_KEY, {16'h0, KEY_REFRESH});
      chk(32'(watchdog_reset_out), 0);
    end
    wait_rst(300, 360);
    software_start_option <= 1'b0;
    apply_rst();
    // a late start key must not restart the free-running count
    repeat (800) @(posedge aclk);
    wr(OFS_KEY, {16'h0, KEY_START});
    wait_rst(tper(0, 4093) - 810, tper(0, 4096) - 760);
    summarize();
  end
endmodule // testbench
`default_nettype wire
